// ---- design/rbr_pkg.sv ----
package rbr_pkg;

	// ----------------------------------------
	// word and counters
	// ----------------------------------------
	localparam int WORD_W = 16;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_LAST = 5'h0f;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int MCLK_HZ = 10_000_000;
	localparam int CYC_PER_US = MCLK_HZ / 1_000_000;
	localparam int BIT_RATE_HZ = 1187;
	localparam int BIT_PERIOD_US = 842;
	localparam int POLL_MAX_US = 13500;
	localparam int POLL_MAX_CYC = POLL_MAX_US * CYC_PER_US;
	localparam int LCLK_HALF_CYC = 8;
	localparam int TMR_W = 24;

	// ----------------------------------------
	// mode select and line levels
	// ----------------------------------------
	localparam logic MODE_DIRECT = 1'b0;
	localparam logic MODE_BUFFERED = 1'b1;
	localparam logic LINE_LOW = 1'b0;
	localparam logic LINE_HIGH = 1'b1;

	// ----------------------------------------
	// reader states
	// ----------------------------------------
	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_LOW = 2'h1,
		H_HIGH = 2'h3,
		H_DONE = 2'h2
	} rbr_host_st_t;

endpackage : rbr_pkg

// ---- design/rbr_link_if.sv ----
`timescale 1ns/1ps
interface rbr_link_if;
	logic lclk;
	logic dev_data_o;
	logic dev_data_oe;
	logic data_line;

	// open-drain data line with pull-up
	assign data_line = dev_data_oe ? dev_data_o : rbr_pkg::LINE_HIGH;

	modport dev (
		input lclk,
		output dev_data_o,
		output dev_data_oe
	);

	modport host (
		output lclk,
		input data_line
	);
endinterface : rbr_link_if

// ---- design/rbr_dev.sv ----
`timescale 1ns/1ps
// Contract
// - direct mode shows each new bit immediately
// - buffered mode collects into one 16-bit register, copies each full word to a single store buffer
// - sixteen bits stored, data line pulled low
// - reader polls data line within 13.5 ms
// - configuration bit selects the readout mode
// - data stays low until clock falls
// - first falling clock edge presents first bit
// - after sixteen pulses data high until refill
// - reader ends readout with clock high
// - next bit shortly after each falling edge
// - reader samples bit at the end of each clock low phase
// - new word overwrites unread buffer, old lost
module rbr_dev #(
	parameter int WORD_W = rbr_pkg::WORD_W
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic bit_i,
	input wire logic bit_stb,
	input wire logic cfg_buffered,
	input wire logic ovr_clr,
	output logic ovr_o,
	output logic word_ready_o,
	rbr_link_if.dev link
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [WORD_W-1:0] col_r;
	logic [WORD_W-1:0] col_nxt;
	logic [rbr_pkg::CNT_W-1:0] cnt_r;
	logic [rbr_pkg::CNT_W-1:0] cnt_nxt;
	logic [WORD_W-1:0] buf_r;
	logic [WORD_W-1:0] buf_nxt;
	logic pend_r;
	logic pend_nxt;
	logic ovr_r;
	logic ovr_nxt;
	logic raw_r;
	logic raw_nxt;
	logic busy_s1_r;
	logic busy_s2_r;
	logic busy_d_r;
	logic read_taken;
	logic [WORD_W-1:0] sh_r;
	logic [WORD_W-1:0] sh_nxt;
	logic go_tgl_r;
	logic go_tgl_nxt;
	logic [rbr_pkg::CNT_W-1:0] pulse_r;
	logic [rbr_pkg::CNT_W-1:0] pulse_nxt;
	logic end_tgl_r;
	logic end_tgl_nxt;
	logic in_frame;
	logic line_low;

	// ----------------------------------------
	// collection and store, system clock
	// ----------------------------------------
	// readout start seen in this domain: stored word now belongs to the link
	assign read_taken = busy_s2_r && !busy_d_r;

	always_comb begin
		col_nxt = col_r;
		cnt_nxt = cnt_r;
		buf_nxt = buf_r;
		pend_nxt = pend_r;
		ovr_nxt = ovr_r;
		raw_nxt = raw_r;
		if (ovr_clr) begin
			ovr_nxt = 1'b0;
		end
		if (read_taken) begin
			pend_nxt = 1'b0;
		end
		if (bit_stb) begin
			raw_nxt = bit_i;
			col_nxt = {col_r[WORD_W-2:0], bit_i};
			if (cfg_buffered == rbr_pkg::MODE_BUFFERED) begin
				if (cnt_r == rbr_pkg::CNT_LAST) begin
					cnt_nxt = rbr_pkg::CNT_ZERO;
					buf_nxt = {col_r[WORD_W-2:0], bit_i};
					pend_nxt = 1'b1;
					if (pend_r && !read_taken) begin
						ovr_nxt = 1'b1;
					end
				end else begin
					cnt_nxt = cnt_r + rbr_pkg::CNT_ONE;
				end
			end
		end
		if (cfg_buffered == rbr_pkg::MODE_DIRECT) begin
			cnt_nxt = rbr_pkg::CNT_ZERO;
			pend_nxt = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			col_r <= rbr_pkg::WORD_ZERO;
			cnt_r <= rbr_pkg::CNT_ZERO;
			buf_r <= rbr_pkg::WORD_ZERO;
			pend_r <= 1'b0;
			ovr_r <= 1'b0;
			raw_r <= rbr_pkg::LINE_HIGH;
		end else begin
			col_r <= col_nxt;
			cnt_r <= cnt_nxt;
			buf_r <= buf_nxt;
			pend_r <= pend_nxt;
			ovr_r <= ovr_nxt;
			raw_r <= raw_nxt;
		end
	end

	// ----------------------------------------
	// frame level into system clock
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			busy_s1_r <= 1'b0;
			busy_s2_r <= 1'b0;
			busy_d_r <= 1'b0;
		end else begin
			busy_s1_r <= in_frame;
			busy_s2_r <= busy_s1_r;
			busy_d_r <= busy_s2_r;
		end
	end

	// ----------------------------------------
	// shift-out buffer, falling link clock
	// ----------------------------------------
	// frame open while the two toggles differ; the link clock stands still
	// between frames, so no edge is counted outside one
	assign in_frame = go_tgl_r ^ end_tgl_r;

	// stored word is stable here: it is written on the same system clock edge that pulls
	// the line low, and the reader reacts only after that
	always_comb begin
		sh_nxt = sh_r;
		go_tgl_nxt = go_tgl_r;
		if (!in_frame) begin
			sh_nxt = buf_r;
			go_tgl_nxt = ~go_tgl_r;
		end else begin
			sh_nxt = {sh_r[WORD_W-2:0], 1'b0};
		end
	end

	always_ff @(negedge link.lclk) begin
		if (rst) begin
			sh_r <= rbr_pkg::WORD_ZERO;
			go_tgl_r <= 1'b0;
		end else begin
			sh_r <= sh_nxt;
			go_tgl_r <= go_tgl_nxt;
		end
	end

	// ----------------------------------------
	// pulse counter, rising link clock
	// ----------------------------------------
	always_comb begin
		pulse_nxt = rbr_pkg::CNT_ZERO;
		end_tgl_nxt = end_tgl_r;
		if (in_frame) begin
			if (pulse_r == rbr_pkg::CNT_LAST) begin
				end_tgl_nxt = ~end_tgl_r;
			end else begin
				pulse_nxt = pulse_r + rbr_pkg::CNT_ONE;
			end
		end
	end

	always_ff @(posedge link.lclk) begin
		if (rst) begin
			pulse_r <= rbr_pkg::CNT_ZERO;
			end_tgl_r <= 1'b0;
		end else begin
			pulse_r <= pulse_nxt;
			end_tgl_r <= end_tgl_nxt;
		end
	end

	// ----------------------------------------
	// data line
	// ----------------------------------------
	always_comb begin
		if (cfg_buffered == rbr_pkg::MODE_DIRECT) begin
			line_low = ~raw_r;
		end else if (in_frame) begin
			line_low = ~sh_r[WORD_W-1];
		end else begin
			line_low = pend_r;
		end
	end

	assign link.dev_data_o = rbr_pkg::LINE_LOW;
	assign link.dev_data_oe = line_low;
	assign ovr_o = ovr_r;
	assign word_ready_o = pend_r;

endmodule : rbr_dev

// ---- design/rbr_host.sv ----
`timescale 1ns/1ps
module rbr_host #(
	parameter int WORD_W = rbr_pkg::WORD_W,
	parameter int POLL_CYC = rbr_pkg::POLL_MAX_CYC,
	parameter int HALF_CYC = rbr_pkg::LCLK_HALF_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic rd_en,
	output logic [WORD_W-1:0] rd_word_o,
	output logic rd_valid_o,
	rbr_link_if.host link
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	localparam int TW = rbr_pkg::TMR_W;
	localparam logic [TW-1:0] POLL_LD = TW'(POLL_CYC - 1);
	localparam logic [TW-1:0] HALF_LD = TW'(HALF_CYC - 1);
	localparam logic [rbr_pkg::TMR_W-1:0] TMR_ZERO = '0;
	localparam logic [rbr_pkg::TMR_W-1:0] TMR_ONE = 24'h000001;

	rbr_pkg::rbr_host_st_t st_r;
	rbr_pkg::rbr_host_st_t st_nxt;
	logic [rbr_pkg::TMR_W-1:0] tmr_r;
	logic [rbr_pkg::TMR_W-1:0] tmr_nxt;
	logic [rbr_pkg::CNT_W-1:0] bit_r;
	logic [rbr_pkg::CNT_W-1:0] bit_nxt;
	logic [WORD_W-1:0] word_r;
	logic [WORD_W-1:0] word_nxt;
	logic [WORD_W-1:0] out_r;
	logic [WORD_W-1:0] out_nxt;
	logic valid_r;
	logic valid_nxt;
	logic lclk_r;
	logic lclk_nxt;
	logic lclk_tgl;
	logic d_s1_r;
	logic d_s2_r;

	// ----------------------------------------
	// data line synchroniser
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			d_s1_r <= rbr_pkg::LINE_HIGH;
			d_s2_r <= rbr_pkg::LINE_HIGH;
		end else begin
			d_s1_r <= link.data_line;
			d_s2_r <= d_s1_r;
		end
	end

	// ----------------------------------------
	// poll and readout sequencer
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		tmr_nxt = tmr_r;
		bit_nxt = bit_r;
		word_nxt = word_r;
		out_nxt = out_r;
		valid_nxt = 1'b0;
		lclk_nxt = lclk_r;
		case (st_r)
			rbr_pkg::H_IDLE: begin
				lclk_nxt = rbr_pkg::LINE_HIGH;
				if (tmr_r != TMR_ZERO) begin
					tmr_nxt = tmr_r - TMR_ONE;
				end else begin
					tmr_nxt = POLL_LD;
					if (rd_en && d_s2_r == rbr_pkg::LINE_LOW) begin
						st_nxt = rbr_pkg::H_LOW;
						tmr_nxt = HALF_LD;
						bit_nxt = rbr_pkg::CNT_ZERO;
						lclk_nxt = rbr_pkg::LINE_LOW;
					end
				end
			end
			rbr_pkg::H_LOW: begin
				if (tmr_r != TMR_ZERO) begin
					tmr_nxt = tmr_r - TMR_ONE;
				end else begin
					// synced sample still shows the bit of the low phase
					word_nxt = {word_r[WORD_W-2:0], d_s2_r};
					lclk_nxt = rbr_pkg::LINE_HIGH;
					tmr_nxt = HALF_LD;
					st_nxt = rbr_pkg::H_HIGH;
				end
			end
			rbr_pkg::H_HIGH: begin
				if (tmr_r != TMR_ZERO) begin
					tmr_nxt = tmr_r - TMR_ONE;
				end else if (bit_r == rbr_pkg::CNT_LAST) begin
					st_nxt = rbr_pkg::H_DONE;
				end else begin
					bit_nxt = bit_r + rbr_pkg::CNT_ONE;
					lclk_nxt = rbr_pkg::LINE_LOW;
					tmr_nxt = HALF_LD;
					st_nxt = rbr_pkg::H_LOW;
				end
			end
			rbr_pkg::H_DONE: begin
				out_nxt = word_r;
				valid_nxt = 1'b1;
				tmr_nxt = POLL_LD;
				st_nxt = rbr_pkg::H_IDLE;
			end
			default: begin
				st_nxt = rbr_pkg::H_IDLE;
				lclk_nxt = rbr_pkg::LINE_HIGH;
			end
		endcase
	end

	// reset-time toggle; an unknown start resolves to high, so the clock runs from the first edge
	always_comb begin
		lclk_tgl = rbr_pkg::LINE_HIGH;
		if (lclk_r == rbr_pkg::LINE_HIGH) begin
			lclk_tgl = rbr_pkg::LINE_LOW;
		end
	end

	// link clock runs during reset so the far end's link logic resets too
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= rbr_pkg::H_IDLE;
			tmr_r <= POLL_LD;
			bit_r <= rbr_pkg::CNT_ZERO;
			word_r <= rbr_pkg::WORD_ZERO;
			out_r <= rbr_pkg::WORD_ZERO;
			valid_r <= 1'b0;
			lclk_r <= lclk_tgl;
		end else begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			bit_r <= bit_nxt;
			word_r <= word_nxt;
			out_r <= out_nxt;
			valid_r <= valid_nxt;
			lclk_r <= lclk_nxt;
		end
	end

	assign link.lclk = lclk_r;
	assign rd_word_o = out_r;
	assign rd_valid_o = valid_r;

endmodule : rbr_host

// ---- bench/rbr_chk.sv ----
`timescale 1ns/1ps
module rbr_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic lclk,
	input wire logic dev_data_o,
	input wire logic dev_data_oe,
	input wire logic data_line,
	input wire logic cfg_buffered,
	input wire logic word_ready_o
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// ----------------------------------------
	// link clock phases
	// ----------------------------------------
	sequence s_low_phase;
		(!lclk) [*8] ##1 lclk;
	endsequence
	sequence s_high_phase;
		lclk [*8];
	endsequence

	chk_low_phase_len: assert property ($fell(lclk) && !$past(rst) |-> s_low_phase)
		else $error("link clock low phase wrong");
	chk_high_phase_len: assert property ($rose(lclk) && !$past(rst) |-> s_high_phase)
		else $error("link clock high phase wrong");

	// ----------------------------------------
	// data line
	// ----------------------------------------
	chk_oe_pulls_low: assert property (dev_data_oe |-> !dev_data_o && !data_line)
		else $error("driven line not low");
	chk_release_high: assert property (!dev_data_oe |-> data_line)
		else $error("released line not high");
	chk_ready_line_low: assert property ($rose(word_ready_o) && cfg_buffered |-> !data_line)
		else $error("full buffer not announced");
	chk_low_until_clk: assert property (word_ready_o && !data_line && lclk |=> !data_line || !lclk)
		else $error("line left low before clock fell");
	chk_bit_stable_high: assert property (cfg_buffered && $past(cfg_buffered) && lclk && $past(lclk)
		&& $stable(word_ready_o) |-> $stable(data_line))
		else $error("bit changed while clock high");
	chk_direct_no_word: assert property (!cfg_buffered && !$past(cfg_buffered) |-> !word_ready_o)
		else $error("word stored in direct mode");
endmodule : rbr_chk

// ---- bench/rbr_tb_top.sv ----
`timescale 1ns/1ps
module rds_buffered_readout_port_tb_top;
	logic mclk, rst, bit_i, bit_stb, cfg_buffered, ovr_clr, rd_en, ovr_o, word_ready_o, rd_valid_o;
	logic [15:0] rd_word_o;
	logic [15:0] mw;
	logic [31:0] lfsr;
	logic [15:0] wq[$];
	int nb, n_mismatch, checks;

	rbr_link_if rbr_link_if_inst ();
	rbr_dev rbr_dev_inst (.mclk(mclk), .rst(rst), .bit_i(bit_i), .bit_stb(bit_stb), .cfg_buffered(cfg_buffered),
		.ovr_clr(ovr_clr), .ovr_o(ovr_o), .word_ready_o(word_ready_o), .link(rbr_link_if_inst.dev));
	rbr_host #(.POLL_CYC(200)) rbr_host_inst (.mclk(mclk), .rst(rst), .rd_en(rd_en), .rd_word_o(rd_word_o),
		.rd_valid_o(rd_valid_o), .link(rbr_link_if_inst.host));
	rbr_chk rbr_chk_inst (.mclk(mclk), .rst(rst), .lclk(rbr_link_if_inst.lclk),
		.dev_data_o(rbr_link_if_inst.dev_data_o), .dev_data_oe(rbr_link_if_inst.dev_data_oe),
		.data_line(rbr_link_if_inst.data_line), .cfg_buffered(cfg_buffered), .word_ready_o(word_ready_o));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr_next

	// one strobed bit, model updated alongside
	task automatic send();
		lfsr = lfsr_next(lfsr);
		bit_i = lfsr[0];
		bit_stb = 1'b1;
		tick(1);
		bit_stb = 1'b0;
		if (cfg_buffered === rbr_pkg::MODE_DIRECT) begin
			chk("direct bit", {15'h0, rbr_link_if_inst.data_line}, {15'h0, lfsr[0]});
		end else begin
			mw = {mw[14:0], lfsr[0]};
			nb++;
			if (nb == 16) begin
				nb = 0;
				wq.delete();
				wq.push_back(mw);
			end
		end
		tick(1);
	endtask : send

	task automatic send_word();
		repeat (16) send();
		chk("word ready", {15'h0, word_ready_o}, 16'h1);
		chk("full line", {15'h0, rbr_link_if_inst.data_line}, 16'h0);
	endtask : send_word

	task automatic read_word();
		int t;
		rd_en = 1'b1;
		t = 0;
		while (rd_valid_o !== 1'b1 && t < 3000) begin
			tick(1);
			t++;
		end
		if (t == 3000) begin
			n_mismatch++;
			print_verdict();
		end
		chk("read word", rd_word_o, wq.pop_front());
		rd_en = 1'b0;
		tick(2);
		chk("idle line", {15'h0, rbr_link_if_inst.data_line}, 16'h1);
	endtask : read_word

	// ----------------------------------------
	// clock and sequence
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	initial begin
		rst = 1'b1;
		bit_i = 1'b0;
		bit_stb = 1'b0;
		cfg_buffered = rbr_pkg::MODE_DIRECT;
		ovr_clr = 1'b0;
		rd_en = 1'b0;
		lfsr = 32'h1fd67893;
		mw = 16'h0000;
		nb = 0;
		n_mismatch = 0;
		checks = 0;
		tick(16);
		rst = 1'b0;
		chk("ovr reset", {15'h0, ovr_o}, 16'h0);
		repeat (8) send();
		cfg_buffered = rbr_pkg::MODE_BUFFERED;
		tick(1);
		repeat (3) begin
			send_word();
			read_word();
		end
		send_word();
		send_word();
		chk("overrun", {15'h0, ovr_o}, 16'h1);
		read_word();
		ovr_clr = 1'b1;
		tick(1);
		ovr_clr = 1'b0;
		tick(1);
		chk("ovr cleared", {15'h0, ovr_o}, 16'h0);
		cfg_buffered = rbr_pkg::MODE_DIRECT;
		tick(1);
		repeat (4) send();
		chk("direct no word", {15'h0, word_ready_o}, 16'h0);
		print_verdict();
	end
endmodule : rds_buffered_readout_port_tb_top
